//--- core/rx_framer_pkg.sv
/*
 * Constants and carrier types for the serial receive framer.
 * Assumes a single 10 MHz clock and a synchronous active-high reset.
 */
package rx_framer_pkg;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          MS_CYCLES       = CLK_HZ / 1000;
    localparam int          BUF_BYTES       = 4096;
    localparam int          PAGE_BYTES      = 14;
    localparam int          TERM_MAX        = 12;
    localparam int          TYPE_TERM_BIT   = 0;
    localparam int          TYPE_MSG_BIT    = 1;
    localparam int          TYPE_GAP_BIT    = 2;
    localparam int          TYPE_LEN_BIT    = 3;
    localparam logic [3:0]  TYPE_STREAM     = 4'h0;
    localparam logic [7:0]  DEFAULT_TERM    = 8'h0d;

    // Baud codes as entered in configuration
    localparam logic [15:0] BAUD_110   = 16'd110;
    localparam logic [15:0] BAUD_150   = 16'd150;
    localparam logic [15:0] BAUD_300   = 16'd300;
    localparam logic [15:0] BAUD_600   = 16'd600;
    localparam logic [15:0] BAUD_1200  = 16'd1200;
    localparam logic [15:0] BAUD_2400  = 16'd2400;
    localparam logic [15:0] BAUD_4800  = 16'd4800;
    localparam logic [15:0] BAUD_9600  = 16'd9600;
    localparam logic [15:0] BAUD_19200 = 16'd19200;
    localparam logic [15:0] BAUD_28800 = 16'd28800;
    localparam logic [15:0] BAUD_38400 = 16'd38400;
    localparam logic [15:0] BAUD_57600 = 16'd57600;
    localparam logic [15:0] BAUD_115K  = 16'd115;

    typedef struct packed {
        logic        enable;
        logic [3:0]  term_type;
        logic [3:0]  terminator_count_setting;
        logic [12:0] packet_length_setting;
        logic [15:0] msg_timeout_ms;
        logic [15:0] gap_timeout_ms;
        logic [15:0] fail_count;
        logic [15:0] baud_code;
    } rx_cfg_s;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } rx_byte_s;
endpackage : rx_framer_pkg

//--- core/rx_framer.sv
/*
 * Receive framer: gathers port bytes, releases them as blocks sent in pages.
 * Assumes bytes arrive as one-cycle strobes from a UART on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // Fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    wp_d;
    logic [AW-1:0]    rp_q;
    logic [AW-1:0]    rp_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             wr;
    logic             rd;

    always_comb begin
        wr    = i_valid && o_ready;
        rd    = o_valid && i_ready;
        wp_d  = wr ? ((wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1) : wp_q;
        rp_d  = rd ? ((rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
        if (wr) mem_q[wp_q] <= i_data;
    end

    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem_q[rp_q];

    a_fifo_count: assert property (@(posedge i_clk) disable iff (i_srst)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("page fifo count over depth");
endmodule : rx_fifo

module rx_framer
    import rx_framer_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_srst,
    // Configuration
    input  wire rx_framer_pkg::rx_cfg_s   i_cfg,
    input  wire logic [TERM_MAX*8-1:0]    i_term_chars,
    // Received bytes from the port
    input  wire logic                     i_rx_valid,
    input  wire logic [7:0]               i_rx_data,
    // Backplane transfer result, one pulse each
    input  wire logic                     i_xfer_ok,
    input  wire logic                     i_xfer_err,
    // Page bytes toward the host image
    output logic                          o_page_valid,
    input  wire logic                     i_page_ready,
    output var rx_framer_pkg::rx_byte_s   o_page_byte,
    // Status
    output logic                          o_port_active,
    output logic                          o_baud_ok,
    output logic                          o_overrun
);
    import rx_framer_pkg::*;

    typedef enum logic [1:0] {ST_COLLECT = 2'b00, ST_SEND = 2'b01} state_e;

    logic [7:0]            buf_q [BUF_BYTES];
    logic [11:0]           wp_q;
    logic [11:0]           wp_d;
    logic [11:0]           rp_q;
    logic [11:0]           rp_d;
    logic [12:0]           cnt_q;
    logic [12:0]           cnt_d;
    logic [12:0]           rel_q;
    logic [12:0]           rel_d;
    logic [12:0]           pend_q;
    logic [12:0]           pend_d;
    logic [3:0]            pg_q;
    logic [3:0]            pg_d;
    logic [15:0]           err_q;
    logic [15:0]           err_d;
    logic                  shut_q;
    logic                  shut_d;
    logic                  ovr_q;
    logic                  ovr_d;
    logic [31:0]           gap_q;
    logic [31:0]           gap_d;
    logic [31:0]           msg_q;
    logic [31:0]           msg_d;
    logic                  msg_run_q;
    logic                  msg_run_d;
    logic [TERM_MAX*8-1:0] hist_q;
    logic [TERM_MAX*8-1:0] hist_d;
    state_e                st_q;
    state_e                st_d;
    logic                  active;
    logic                  take;
    logic                  pop;
    logic                  stream;
    logic                  hit;
    logic                  term_hit;
    logic                  gap_hit;
    logic                  msg_hit;
    logic                  len_hit;
    logic                  full_hit;
    logic [12:0]           blk_n;
    logic [31:0]           gap_lim;
    logic [31:0]           msg_lim;
    logic                  f_ready;
    rx_byte_s              f_in;

    function automatic logic [31:0] ms_to_cyc(input logic [15:0] ms);
        ms_to_cyc = 32'(ms) * 32'(MS_CYC);
    endfunction : ms_to_cyc

    always_comb begin
        case (i_cfg.baud_code)
            BAUD_110, BAUD_150, BAUD_300, BAUD_600, BAUD_1200, BAUD_2400,
            BAUD_4800, BAUD_9600, BAUD_19200, BAUD_28800, BAUD_38400,
            BAUD_57600, BAUD_115K: o_baud_ok = 1'b1;
            default:               o_baud_ok = 1'b0;
        endcase
    end

    assign active   = i_cfg.enable && !shut_q;
    assign stream   = (i_cfg.term_type == TYPE_STREAM);
    // Incoming bytes dropped when the port is inactive or the buffer is truly full
    assign take     = active && i_rx_valid && (cnt_q != 13'(BUF_BYTES));
    assign gap_lim  = ms_to_cyc(i_cfg.gap_timeout_ms);
    assign msg_lim  = ms_to_cyc(i_cfg.msg_timeout_ms);

    always_comb begin
        // Terminator sequence checked with the newest byte included
        hist_d   = take ? {hist_q[TERM_MAX*8-9:0], i_rx_data} : hist_q;
        term_hit = take && i_cfg.term_type[TYPE_TERM_BIT] && (i_cfg.terminator_count_setting != 4'h0);
        for (int i = 0; i < TERM_MAX; i++) begin
            if (i < int'(i_cfg.terminator_count_setting) &&
                hist_d[i*8 +: 8] != i_term_chars[(int'(i_cfg.terminator_count_setting)-1-i)*8 +: 8])
                term_hit = 1'b0;
        end
    end

    always_comb begin
        blk_n    = cnt_q - pend_q + 13'(take);
        gap_hit  = i_cfg.term_type[TYPE_GAP_BIT] && (blk_n != '0) && !take && (gap_q >= gap_lim);
        msg_hit  = i_cfg.term_type[TYPE_MSG_BIT] && msg_run_q && (msg_q >= msg_lim);
        len_hit  = take && i_cfg.term_type[TYPE_LEN_BIT] && (i_cfg.packet_length_setting != '0) &&
                   (blk_n == i_cfg.packet_length_setting);
        full_hit = take && (cnt_q + 13'd1 == 13'(BUF_BYTES));
        // First enabled condition met closes the block
        hit      = (stream && take) || term_hit || gap_hit || msg_hit || len_hit || full_hit;
        // Pops taken off here so the register stage only copies
        rel_d    = (hit ? pend_q + blk_n : pend_q) - 13'(pop);
        pend_d   = rel_d;
        gap_d    = take ? '0 : ((gap_q == '1) ? gap_q : gap_q + 32'd1);
        msg_run_d = hit ? 1'b0 : (msg_run_q || take);
        msg_d    = (!msg_run_q) ? '0 : msg_q + 32'd1;
        wp_d     = take ? wp_q + 12'd1 : wp_q;
    end

    always_comb begin
        // Page closes at 14 bytes or end of released data
        f_in.last = (pg_q == 4'(PAGE_BYTES-1)) || (rel_q == 13'd1);
        f_in.data = buf_q[rp_q];
        pop       = 1'b0;
        st_d      = st_q;
        pg_d      = pg_q;
        rp_d      = rp_q;
        case (st_q)
            ST_COLLECT: if (rel_q != '0) st_d = ST_SEND;
            ST_SEND: if (f_ready) begin
                pop  = 1'b1;
                rp_d = rp_q + 12'd1;
                pg_d = (f_in.last) ? 4'h0 : pg_q + 4'h1;
                if (rel_q == 13'd1) st_d = ST_COLLECT;
            end
            default: st_d = ST_COLLECT;
        endcase
        cnt_d     = cnt_q + 13'(take) - 13'(pop);
        ovr_d     = ovr_q || (active && i_rx_valid && !take);
        // Successive errors count up; a good transfer clears the run
        err_d     = i_xfer_ok ? '0 : (i_xfer_err && err_q != '1) ? err_q + 16'd1 : err_q;
        shut_d    = shut_q || ((i_cfg.fail_count != '0) && (err_d >= i_cfg.fail_count));
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wp_q      <= '0;
            rp_q      <= '0;
            cnt_q     <= '0;
            rel_q     <= '0;
            pend_q    <= '0;
            pg_q      <= '0;
            err_q     <= '0;
            shut_q    <= 1'b0;
            ovr_q     <= 1'b0;
            gap_q     <= '0;
            msg_q     <= '0;
            msg_run_q <= 1'b0;
            hist_q    <= '0;
            st_q      <= ST_COLLECT;
        end else begin
            wp_q      <= wp_d;
            rp_q      <= rp_d;
            cnt_q     <= cnt_d;
            rel_q     <= rel_d;
            pend_q    <= pend_d;
            pg_q      <= pg_d;
            err_q     <= err_d;
            shut_q    <= shut_d;
            ovr_q     <= ovr_d;
            gap_q     <= gap_d;
            msg_q     <= msg_d;
            msg_run_q <= msg_run_d;
            hist_q    <= hist_d;
            st_q      <= st_d;
        end
        if (take) buf_q[wp_q] <= i_rx_data;
    end

    rx_fifo #(.WIDTH(9), .DEPTH(4)) u_fifo (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_valid (st_q == ST_SEND),
        .o_ready (f_ready),
        .i_data  (f_in),
        .o_valid (o_page_valid),
        .i_ready (i_page_ready),
        .o_data  (o_page_byte)
    );

    assign o_port_active = active;
    assign o_overrun     = ovr_q;

    // Release and status checks: each enabled condition must open the send path
    a_term_release: assert property (@(posedge i_clk) disable iff (i_srst)
        term_hit |=> rel_q != '0)
        else $error("terminator did not release");
    a_gap_restart: assert property (@(posedge i_clk) disable iff (i_srst)
        take |=> gap_q == '0)
        else $error("gap timer not restarted");
    a_gap_release: assert property (@(posedge i_clk) disable iff (i_srst)
        gap_hit |=> rel_q != '0)
        else $error("gap expiry did not release");
    a_len_release: assert property (@(posedge i_clk) disable iff (i_srst)
        len_hit |=> rel_q >= $past(i_cfg.packet_length_setting))
        else $error("length block wrong");
    a_full_flush: assert property (@(posedge i_clk) disable iff (i_srst)
        full_hit |=> rel_q != '0)
        else $error("full buffer not flushed");
    a_buf_bound: assert property (@(posedge i_clk) disable iff (i_srst)
        pend_q <= cnt_q && cnt_q <= 13'(BUF_BYTES))
        else $error("buffer count out of range");
    a_page_limit: assert property (@(posedge i_clk) disable iff (i_srst)
        pg_q < 4'(PAGE_BYTES))
        else $error("page over 14 bytes");
    a_fail_shut: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_cfg.fail_count != '0 && err_d >= i_cfg.fail_count) |=> !o_port_active)
        else $error("no shutdown");
    a_shut_hold: assert property (@(posedge i_clk) disable iff (i_srst)
        shut_q |=> shut_q)
        else $error("shutdown released without reset");
    a_err_clear: assert property (@(posedge i_clk) disable iff (i_srst)
        i_xfer_ok |=> err_q == '0)
        else $error("error run not cleared");
    a_port_off: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_cfg.enable |-> !take)
        else $error("disabled port took byte");
    a_stream_now: assert property (@(posedge i_clk) disable iff (i_srst)
        (stream && take) |=> rel_q != '0)
        else $error("stream byte held");
    a_msg_release: assert property (@(posedge i_clk) disable iff (i_srst)
        msg_hit |=> rel_q != '0)
        else $error("message timeout did not release");

    c_term: cover property (@(posedge i_clk) term_hit);
    c_msg: cover property (@(posedge i_clk) msg_hit);
    c_gap: cover property (@(posedge i_clk) gap_hit);
    c_len: cover property (@(posedge i_clk) len_hit);
    c_full: cover property (@(posedge i_clk) full_hit);
endmodule : rx_framer

`default_nettype wire

//--- dv/serial_device_model.sv
/*
 * Model of the serial device on the application port: one-cycle byte strobes.
 * Assumes the framer samples the strobe on the rising edge of i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_device_model (
    // Clock
    input  wire logic       i_clk,
    // Byte strobe toward the framer
    output logic            o_valid,
    output logic [7:0]      o_data
);
    initial begin
        o_valid = 1'b0;
        o_data  = 8'h00;
    end

    // Gap of zero sends bytes back to back
    task automatic send(input string s, input int gap);
        foreach (s[i]) begin
            @(posedge i_clk);
            o_valid <= 1'b1;
            o_data  <= s[i];
            if (gap > 0) begin
                @(posedge i_clk);
                o_valid <= 1'b0;
                // Idle line between bytes never repeats the last byte
                o_data  <= ~s[i];
                repeat (gap - 1) @(posedge i_clk);
            end
        end
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_data  <= ~o_data;
    endtask : send
endmodule : serial_device_model
`default_nettype wire

//--- dv/testbench.sv
/*
 * Self-checking bench for rx_framer: termination modes, pages, status.
 * Assumes serial_device_model drives the receive strobe; host side always sampled.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rx_framer_pkg::*;
    logic i_clk, i_srst, rx_valid, xfer_ok, xfer_err;
    logic page_valid, page_ready, port_active, baud_ok, overrun;
    logic [7:0] rx_data;
    rx_cfg_s    cfg;
    rx_byte_s   page_byte;
    rx_byte_s   rx_q[$];
    logic [TERM_MAX*8-1:0] term_chars;
    string      big;
    int         errors, samples_checked, cycles;
    localparam logic [15:0] BAUDS[13] = '{BAUD_110, BAUD_150, BAUD_300, BAUD_600, BAUD_1200,
        BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200, BAUD_28800, BAUD_38400, BAUD_57600, BAUD_115K};

    serial_device_model u_dev (.i_clk(i_clk), .o_valid(rx_valid), .o_data(rx_data));
    rx_framer #(.MS_CYC(10)) u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_cfg(cfg),
        .i_term_chars(term_chars), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
        .i_xfer_ok(xfer_ok), .i_xfer_err(xfer_err), .o_page_valid(page_valid),
        .i_page_ready(page_ready), .o_page_byte(page_byte), .o_port_active(port_active),
        .o_baud_ok(baud_ok), .o_overrun(overrun));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        if (page_valid && page_ready)
            rx_q.push_back(page_byte);
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Page end at every 14th byte and at block end
    task automatic expect_blk(input string s);
        int n;
        logic last;
        for (int i = 0; i < s.len(); i++) begin
            for (n = 0; n < 200 && rx_q.size() == 0; n++) @(posedge i_clk);
            last = (i == s.len() - 1) || (i % 14 == 13);
            check("page byte", rx_q.size() ? {7'h00, rx_q.pop_front()} : 16'hffff, {7'h00, last, s[i]});
        end
    endtask : expect_blk

    task automatic expect_none();
        repeat (30) @(posedge i_clk);
        check("held bytes", 16'(rx_q.size()), 16'h0000);
    endtask : expect_none

    task automatic do_reset(input logic [3:0] ttype, input logic [12:0] plen);
        @(posedge i_clk);
        i_srst <= 1'b1;
        cfg.term_type <= ttype;
        cfg.packet_length_setting <= plen;
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        rx_q.delete();
    endtask : do_reset

    task automatic pulse(input logic err);
        @(posedge i_clk);
        xfer_err <= err;
        xfer_ok <= !err;
        @(posedge i_clk);
        xfer_err <= 1'b0;
        xfer_ok <= 1'b0;
    endtask : pulse

    task automatic conclude();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude

    initial begin
        {i_srst, xfer_ok, xfer_err, page_ready} = 4'h9;
        {errors, samples_checked, cycles} = '0;
        cfg = '{1'b1, 4'h0, 4'h1, 13'h0000, 16'h0003, 16'h0001, 16'h0000, BAUD_19200};
        term_chars = 96'h0d;
        do_reset(4'h0, 13'h0000);
        u_dev.send("A", 2);
        expect_blk("A");
        do_reset(4'h1, 13'h0000);
        u_dev.send("ABC\rDE", 0);
        expect_blk("ABC\r");
        expect_none();
        do_reset(4'h4, 13'h0000);
        u_dev.send("ABCDEF", 3);
        repeat (30) @(posedge i_clk);
        u_dev.send("GH", 3);
        expect_blk("ABCDEF");
        expect_blk("GH");
        do_reset(4'h2, 13'h0000);
        u_dev.send("AB", 2);
        repeat (10) @(posedge i_clk);
        check("early release", 16'(rx_q.size()), 16'h0000);
        expect_blk("AB");
        do_reset(4'h8, 13'h0004);
        u_dev.send("ABCDEFGHIJ", 0);
        expect_blk("ABCDEFGH");
        expect_none();
        do_reset(4'h9, 13'h0004);
        u_dev.send("A\rBCDE", 0);
        expect_blk("A\r");
        expect_blk("BCDE");
        // Host stalls so the FIFO fills and must hold its head byte
        do_reset(4'h8, 13'h0014);
        page_ready <= 1'b0;
        u_dev.send("ABCDEFGHIJKLMNOPQRST", 0);
        repeat (20) @(negedge i_clk);
        check("stalled valid", {15'h0000, page_valid}, 16'h0001);
        @(posedge i_clk);
        page_ready <= 1'b1;
        expect_blk("ABCDEFGHIJKLMNOPQRST");
        do_reset(4'h0, 13'h0000);
        cfg.enable <= 1'b0;
        u_dev.send("Z", 2);
        expect_none();
        check("port off", {15'h0000, port_active}, 16'h0000);
        cfg.enable <= 1'b1;
        cfg.fail_count <= 16'h0002;
        do_reset(4'h0, 13'h0000);
        pulse(1'b1);
        pulse(1'b0);
        pulse(1'b1);
        @(negedge i_clk);
        check("run cleared", {15'h0000, port_active}, 16'h0001);
        pulse(1'b1);
        @(negedge i_clk);
        check("shut down", {15'h0000, port_active}, 16'h0000);
        u_dev.send("Z", 2);
        expect_none();
        cfg.fail_count <= 16'h0000;
        do_reset(4'h0, 13'h0000);
        repeat (3) pulse(1'b1);
        @(negedge i_clk);
        check("never shut", {15'h0000, port_active}, 16'h0001);
        foreach (BAUDS[i]) begin
            @(posedge i_clk);
            cfg.baud_code <= BAUDS[i];
            @(negedge i_clk);
            check("baud ok", {15'h0000, baud_ok}, 16'h0001);
        end
        @(posedge i_clk);
        cfg.baud_code <= 16'h0000;
        @(negedge i_clk);
        check("baud bad", {15'h0000, baud_ok}, 16'h0000);
        // Two-byte terminator: a lone first byte must not end the block
        cfg.terminator_count_setting <= 4'h2;
        term_chars <= 96'h0a0d;
        do_reset(4'h1, 13'h0000);
        u_dev.send("AB\rC\r\nD", 0);
        expect_blk("AB\rC\r\n");
        expect_none();
        do_reset(4'h1, 13'h0000);
        big = "";
        repeat (4096) big = {big, "x"};
        u_dev.send(big, 0);
        for (int n = 0; n < 10000 && rx_q.size() < 4096; n++) @(posedge i_clk);
        check("full flush", 16'(rx_q.size()), 16'h1000);
        check("first page", {15'h0000, rx_q[13].last}, 16'h0001);
        check("no overrun", {15'h0000, overrun}, 16'h0000);
        conclude();
    end
endmodule : testbench
`default_nettype wire
